// File: dwr_pkg.sv
// shared constants for the dual watchdog reset block
package dwr_pkg;

  // register byte offsets on the avalon slave
  localparam logic [5:0] OFF_IW_KEY   = 6'h00;
  localparam logic [5:0] OFF_IW_PSC   = 6'h04;
  localparam logic [5:0] OFF_IW_RLD   = 6'h08;
  localparam logic [5:0] OFF_IW_CNT   = 6'h0c;
  localparam logic [5:0] OFF_WW_CTRL  = 6'h10;
  localparam logic [5:0] OFF_WW_CFG   = 6'h14;
  localparam logic [5:0] OFF_INT_STAT = 6'h18;
  localparam logic [5:0] OFF_INT_CLR  = 6'h1c;
  localparam logic [5:0] OFF_INT_EN   = 6'h20;

  // key values for the independent watchdog key register
  localparam logic [15:0] KEY_RELOAD = 16'haaaa;
  localparam logic [15:0] KEY_START  = 16'hcccc;
  localparam logic [15:0] KEY_UNLOCK = 16'h5555;

  // counter and prescaler widths
  localparam int unsigned IW_CNT_W  = 12;
  localparam int unsigned IW_PSC_W  = 8;
  localparam int unsigned WW_CNT_W  = 7;
  localparam int unsigned WW_TB_W   = 2;
  localparam int unsigned WW_DIV_W  = 16;
  localparam int unsigned WW_PRE_W  = 3;

  // field positions
  localparam int unsigned WW_EN_BIT    = 7;
  localparam int unsigned CFG_TB_LSB   = 7;
  localparam int unsigned INT_EWI_BIT  = 0;
  localparam int unsigned IW_ACT_BIT   = 15;
  localparam int unsigned IW_LOCK_BIT  = 14;

  // reset values
  localparam logic [IW_CNT_W-1:0] IW_RLD_RST = 12'hfff;
  localparam logic [IW_PSC_W-1:0] IW_PSC_RST = 8'h03;
  localparam logic [WW_CNT_W-1:0] WW_CNT_RST = 7'h7f;
  localparam logic [WW_CNT_W-1:0] WW_WIN_RST = 7'h7f;
  localparam logic [WW_TB_W-1:0]  WW_TB_RST  = 2'h0;

  // window watchdog thresholds
  localparam logic [WW_CNT_W-1:0] WW_EARLY   = 7'h40;
  localparam logic [WW_CNT_W-1:0] WW_PRE_EWI = 7'h41;

  // default bus clock divide ahead of the window counter
  localparam int unsigned WW_BASE_DIV_DEF = 4096;

endpackage

// File: dwr_tick_div.sv
// programmable tick divider: one tick per (limit+1) steps
`timescale 1ns/10ps
module dwr_tick_div #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic         run_i,
  input  wire logic         step_i,
  input  wire logic [W-1:0] limit_i,
  output logic              tick_o
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } dwr_div_st_t;

  dwr_div_st_t st_ff;
  dwr_div_st_t nxt_st;

  // count steps, wrap and pulse at the limit
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.tick = 1'b0;
    if (!run_i) begin
      nxt_st.cnt = '0;
    end else if (step_i) begin
      if (st_ff.cnt >= limit_i) begin
        nxt_st.cnt  = '0;
        nxt_st.tick = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + W'(1);
      end
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick_o = st_ff.tick;

endmodule

// File: dwr_watchdog.sv
// dual watchdog: independent and window watchdog with avalon registers
//
// Implementation choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
module dwr_watchdog
  import dwr_pkg::*;
#(
  parameter int unsigned WW_BASE_DIV = WW_BASE_DIV_DEF
) (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        lsi_clk_i,
  input  wire logic        sleep_i,
  input  wire logic [5:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic             irq_o,
  output logic             sys_reset_o
);

  typedef struct packed {
    logic                lsi_s1;
    logic                lsi_s2;
    logic                lsi_s3;
    logic                sleep_s1;
    logic                sleep_s2;
    logic                ack;
    logic [31:0]         rdata;
    logic                iw_active;
    logic                iw_unlock;
    logic [IW_CNT_W-1:0] iw_cnt;
    logic [IW_CNT_W-1:0] iw_rld;
    logic [IW_PSC_W-1:0] iw_psc;
    logic                ww_en;
    logic [WW_CNT_W-1:0] ww_cnt;
    logic [WW_CNT_W-1:0] ww_win;
    logic [WW_TB_W-1:0]  ww_tb;
    logic [WW_PRE_W-1:0] ww_pre;
    logic                ewi_flag;
    logic                ewi_en;
    logic                sys_rst;
  } dwr_st_t;

  localparam logic [WW_DIV_W-1:0] WW_DIV_LIM = WW_DIV_W'(WW_BASE_DIV - 1);

  dwr_st_t st_ff;
  dwr_st_t nxt_st;

  logic lsi_rise;
  logic iw_tick;
  logic ww_base_tick;
  logic ww_tick;
  logic bus_req;
  logic wr_fire;
  logic rd_take;
  logic [31:0] wdata_m;
  logic [31:0] psc_m;
  logic [31:0] rld_m;
  logic [31:0] cfg_m;
  logic        ww_refresh;
  logic [WW_PRE_W-1:0] ww_pre_mask;

  // merge write data into an old word under byte enables
  function automatic logic [31:0] be_merge(
    input logic [31:0] old_w,
    input logic [31:0] new_w,
    input logic [3:0]  be
  );
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return res;
  endfunction

  // read value of a register, zero for write-only or unmapped
  function automatic logic [31:0] reg_view(
    input dwr_st_t    s,
    input logic [5:0] addr
  );
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (addr)
      // independent prescale limit
      OFF_IW_PSC: begin
        v[IW_PSC_W-1:0] = s.iw_psc;
      end
      // independent reload value
      OFF_IW_RLD: begin
        v[IW_CNT_W-1:0] = s.iw_rld;
      end
      // live count with lock and active flags
      OFF_IW_CNT: begin
        v[IW_CNT_W-1:0] = s.iw_cnt;
        v[IW_LOCK_BIT]  = ~s.iw_unlock;
        v[IW_ACT_BIT]   = s.iw_active;
      end
      // window count and enable
      OFF_WW_CTRL: begin
        v[WW_CNT_W-1:0] = s.ww_cnt;
        v[WW_EN_BIT]    = s.ww_en;
      end
      // window value and timebase
      OFF_WW_CFG: begin
        v[WW_CNT_W-1:0]                   = s.ww_win;
        v[CFG_TB_LSB +: WW_TB_W]          = s.ww_tb;
      end
      OFF_INT_STAT: begin
        v[INT_EWI_BIT] = s.ewi_flag;
      end
      OFF_INT_EN: begin
        v[INT_EWI_BIT] = s.ewi_en;
      end
      default: begin
        v = 32'h0000_0000;
      end
    endcase
    return v;
  endfunction

  // independent prescaler, stepped by synchronised rc edges
  dwr_tick_div #(
    .W (IW_PSC_W)
  ) u_iw_psc (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .run_i    (st_ff.iw_active),
    .step_i   (lsi_rise),
    .limit_i  (st_ff.iw_psc),
    .tick_o   (iw_tick)
  );

  // bus clock divider ahead of the window counter, held in sleep
  dwr_tick_div #(
    .W (WW_DIV_W)
  ) u_ww_div (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .run_i    (1'b1),
    .step_i   (~st_ff.sleep_s2),
    .limit_i  (WW_DIV_LIM),
    .tick_o   (ww_base_tick)
  );

  // rising edge of the low-speed rc clock after synchronisation
  assign lsi_rise = st_ff.lsi_s2 & ~st_ff.lsi_s3;

  // extra timebase divide by a power of two
  assign ww_pre_mask = WW_PRE_W'((4'h1 << st_ff.ww_tb) - 4'h1);
  assign ww_tick     = ww_base_tick &
                       ((st_ff.ww_pre & ww_pre_mask) == ww_pre_mask);

  // bus handshake: one wait state, write lands on the release edge
  assign bus_req = avs_read_i | avs_write_i;
  assign wr_fire = avs_write_i & st_ff.ack;
  assign rd_take = avs_read_i & ~st_ff.ack;
  assign wdata_m = be_merge(32'h0000_0000, avs_writedata_i,
                            avs_byteenable_i);

  // write data laid over the present field contents
  assign psc_m = be_merge(32'(st_ff.iw_psc), avs_writedata_i,
                          avs_byteenable_i);
  assign rld_m = be_merge(32'(st_ff.iw_rld), avs_writedata_i,
                          avs_byteenable_i);
  assign cfg_m = be_merge(32'(st_ff.ww_tb) << CFG_TB_LSB,
                          avs_writedata_i, avs_byteenable_i);

  // refresh strobe: a landing write to the control low byte
  assign ww_refresh = wr_fire && avs_address_i == OFF_WW_CTRL &&
                      avs_byteenable_i[0];

  // next state of the whole block
  always_comb begin
    nxt_st = st_ff;

    // rc clock synchroniser and edge history
    nxt_st.lsi_s1 = lsi_clk_i;
    nxt_st.lsi_s2 = st_ff.lsi_s1;
    nxt_st.lsi_s3 = st_ff.lsi_s2;

    // sleep level from the power controller, two flops deep
    nxt_st.sleep_s1 = sleep_i;
    nxt_st.sleep_s2 = st_ff.sleep_s1;

    // bus acknowledge and read capture
    nxt_st.ack = bus_req & ~st_ff.ack;
    if (rd_take) begin
      nxt_st.rdata = reg_view(st_ff, avs_address_i);
    end

    // independent counter counts regardless of sleep, on rc edges sampled by the bus clock;
    // it parks at zero so the reset request below stays asserted
    if (st_ff.iw_active && iw_tick && st_ff.iw_cnt != '0) begin
      nxt_st.iw_cnt = st_ff.iw_cnt - IW_CNT_W'(1);
    end

    // window counter free-runs on every divided tick
    if (ww_base_tick) begin
      nxt_st.ww_pre = st_ff.ww_pre + WW_PRE_W'(1);
    end
    if (ww_tick) begin
      nxt_st.ww_cnt = st_ff.ww_cnt - WW_CNT_W'(1);
    end

    // software writes take priority over counting
    if (wr_fire) begin
      unique case (avs_address_i)
        // key word: start, reload or unlock
        OFF_IW_KEY: begin
          if (wdata_m[15:0] == KEY_START) begin
            nxt_st.iw_active = 1'b1;
            nxt_st.iw_cnt    = st_ff.iw_rld;
          end else if (wdata_m[15:0] == KEY_RELOAD) begin
            nxt_st.iw_cnt    = st_ff.iw_rld;
            nxt_st.iw_unlock = 1'b0;
          end else if (wdata_m[15:0] == KEY_UNLOCK) begin
            nxt_st.iw_unlock = 1'b1;
          end else begin
            nxt_st.iw_unlock = 1'b0;
          end
        end
        // prescale limit, only while unlocked
        OFF_IW_PSC: begin
          if (st_ff.iw_unlock) begin
            nxt_st.iw_psc = psc_m[IW_PSC_W-1:0];
          end
        end
        // reload value, only while unlocked
        OFF_IW_RLD: begin
          if (st_ff.iw_unlock) begin
            nxt_st.iw_rld = rld_m[IW_CNT_W-1:0];
          end
        end
        // refresh of the window counter
        OFF_WW_CTRL: begin
          if (ww_refresh) begin
            nxt_st.ww_cnt = avs_writedata_i[WW_CNT_W-1:0];
            // refresh too early is a window violation
            if (st_ff.ww_en && st_ff.ww_cnt > st_ff.ww_win) begin
              nxt_st.sys_rst = 1'b1;
            end
            // enable can be set but never cleared by software
            if (avs_writedata_i[WW_EN_BIT]) begin
              nxt_st.ww_en = 1'b1;
            end
          end
        end
        // window value and timebase
        OFF_WW_CFG: begin
          if (avs_byteenable_i[0]) begin
            nxt_st.ww_win = avs_writedata_i[WW_CNT_W-1:0];
          end
          if (avs_byteenable_i[1] || avs_byteenable_i[0]) begin
            nxt_st.ww_tb = cfg_m[CFG_TB_LSB +: WW_TB_W];
          end
        end
        // write one to clear the warning flag
        OFF_INT_CLR: begin
          if (wdata_m[INT_EWI_BIT]) begin
            nxt_st.ewi_flag = 1'b0;
          end
        end
        // interrupt enable
        OFF_INT_EN: begin
          if (avs_byteenable_i[0]) begin
            nxt_st.ewi_en = avs_writedata_i[INT_EWI_BIT];
          end
        end
        // read-only and unmapped places ignore writes
        default: begin
          nxt_st.ewi_flag = st_ff.ewi_flag;
        end
      endcase
    end

    // early warning as the counter steps down onto 0x40; comes after
    // the clear above so that a same-cycle set wins
    if (st_ff.ww_en && ww_tick && st_ff.ww_cnt == WW_PRE_EWI &&
        !ww_refresh) begin
      nxt_st.ewi_flag = 1'b1;
    end

    // enabled window watchdog below 0x40 requests a reset
    if (st_ff.ww_en && !st_ff.ww_cnt[WW_CNT_W-1]) begin
      nxt_st.sys_rst = 1'b1;
    end

    // active independent watchdog at zero requests a reset
    if (st_ff.iw_active && st_ff.iw_cnt == '0) begin
      nxt_st.sys_rst = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st_ff.lsi_s1    <= 1'b0;
      st_ff.lsi_s2    <= 1'b0;
      st_ff.lsi_s3    <= 1'b0;
      st_ff.sleep_s1  <= 1'b0;
      st_ff.sleep_s2  <= 1'b0;
      st_ff.ack       <= 1'b0;
      st_ff.rdata     <= 32'h0000_0000;
      st_ff.iw_active <= 1'b0;
      st_ff.iw_unlock <= 1'b0;
      st_ff.iw_cnt    <= IW_RLD_RST;
      st_ff.iw_rld    <= IW_RLD_RST;
      st_ff.iw_psc    <= IW_PSC_RST;
      st_ff.ww_en     <= 1'b0;
      st_ff.ww_cnt    <= WW_CNT_RST;
      st_ff.ww_win    <= WW_WIN_RST;
      st_ff.ww_tb     <= WW_TB_RST;
      st_ff.ww_pre    <= '0;
      st_ff.ewi_flag  <= 1'b0;
      st_ff.ewi_en    <= 1'b0;
      st_ff.sys_rst   <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs
  assign avs_readdata_o    = st_ff.rdata;
  assign avs_waitrequest_o = bus_req & ~st_ff.ack;
  assign irq_o             = st_ff.ewi_flag & st_ff.ewi_en;
  assign sys_reset_o       = st_ff.sys_rst;

endmodule

// File: dwr_watchdog_sva.sv
// bus and reset assertions for the dual watchdog reset block
`timescale 1ns/10ps
module dwr_watchdog_sva
  import dwr_pkg::*;
#(
  parameter int unsigned WW_BASE_DIV = WW_BASE_DIV_DEF
) (
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic        lsi_clk_i,
  input wire logic        sleep_i,
  input wire logic [5:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        irq_o,
  input wire logic        sys_reset_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  // a read finishing at one offset
  sequence s_rd_done(a);
    avs_read_i && !avs_waitrequest_o && avs_address_i == a;
  endsequence

  // at most one wait state, none while idle
  a_one_wait: assert property ((avs_read_i || avs_write_i)
    && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("wait");
  a_idle_no_wait: assert property (!avs_read_i && !avs_write_i
    |-> !avs_waitrequest_o) else $error("idle wait");
  // reset request holds until system reset
  a_reset_sticky: assert property (sys_reset_o |=> sys_reset_o)
    else $error("reset dropped");
  // unmapped and write-only places read zero
  a_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o
    && avs_address_i >= 6'h24 |-> avs_readdata_o == 32'h0)
    else $error("unmapped data");
  a_wo_zero: assert property (avs_read_i && !avs_waitrequest_o
    && (avs_address_i == OFF_IW_KEY || avs_address_i == OFF_INT_CLR)
    |-> avs_readdata_o == 32'h0) else $error("wo data");
  // interrupt only from a set flag
  a_irq_flag: assert property (s_rd_done(OFF_INT_STAT) ##0 $past(irq_o)
    |-> avs_readdata_o[INT_EWI_BIT]) else $error("irq without flag");
  // enabled window count below 0x40 resets
  a_ww_low_reset: assert property (s_rd_done(OFF_WW_CTRL)
    ##0 avs_readdata_o[WW_EN_BIT] && !avs_readdata_o[6] |-> sys_reset_o)
    else $error("no window reset");
  // active independent count at zero resets
  a_iw_zero_reset: assert property (s_rd_done(OFF_IW_CNT)
    ##0 avs_readdata_o[IW_ACT_BIT] && avs_readdata_o[11:0] == 12'h000
    |-> sys_reset_o) else $error("no independent reset");
endmodule

bind dwr_watchdog dwr_watchdog_sva #(.WW_BASE_DIV(WW_BASE_DIV)) u_sva (
  .clk_i(clk_i), .resetn_i(resetn_i), .lsi_clk_i(lsi_clk_i),
  .sleep_i(sleep_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .irq_o(irq_o), .sys_reset_o(sys_reset_o));

// File: dual_watchdog_reset_tb_top.sv
// self-checking bench for the dual watchdog reset block
`timescale 1ns/10ps
module dual_watchdog_reset_tb_top;
  import dwr_pkg::*;
  typedef struct {logic w; logic [5:0] a; logic [31:0] d;} dwr_row_t;
  logic        clk_i, resetn_i, lsi_clk_i, sleep_i;
  logic [5:0]  avs_address_i;
  logic        avs_read_i, avs_write_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic [3:0]  avs_byteenable_i;
  logic        avs_waitrequest_o, irq_o, sys_reset_o;
  int          miscompares, comparisons, n;
  // reset values, locked writes, unmapped places
  dwr_row_t rows [14] = '{'{1'b0, OFF_IW_PSC, 32'h3},
    '{1'b0, OFF_IW_RLD, 32'hfff}, '{1'b0, OFF_WW_CFG, 32'h7f},
    '{1'b0, OFF_INT_STAT, 32'h0}, '{1'b0, OFF_INT_EN, 32'h0},
    '{1'b0, OFF_IW_KEY, 32'h0}, '{1'b0, OFF_INT_CLR, 32'h0},
    '{1'b1, 6'h24, 32'h5}, '{1'b0, 6'h24, 32'h0},
    '{1'b1, OFF_IW_PSC, 32'h0}, '{1'b0, OFF_IW_PSC, 32'h3},
    '{1'b1, OFF_INT_EN, 32'h1}, '{1'b0, OFF_INT_EN, 32'h1},
    '{1'b1, OFF_INT_EN, 32'h0}};

  dwr_watchdog #(.WW_BASE_DIV(4)) u_dut (.clk_i(clk_i), .resetn_i(resetn_i),
    .lsi_clk_i(lsi_clk_i), .sleep_i(sleep_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .irq_o(irq_o), .sys_reset_o(sys_reset_o));

  // clocks: main 100 ns, slow rc one eighth of it
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    lsi_clk_i = 1'b0;
    forever begin
      repeat (4) @(posedge clk_i);
      lsi_clk_i <= ~lsi_clk_i;
    end
  end
  // hang guard: the whole run needs roughly 2500 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    close_out;
  end

  task close_out;
    $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [33:0] g, input logic [33:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // one avalon transfer, held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
    avs_write_i     <= w;
    avs_read_i      <= !w;
    avs_address_i   <= a;
    avs_writedata_i <= d;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0) begin
      @(posedge clk_i);
    end
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    // one idle edge before the next request
    @(posedge clk_i);
  endtask
  task rst;
    resetn_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
  endtask
  // count cycles until irq (sel 1) or reset request (sel 0)
  task wait_sig(input logic sel, input int lim);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while ((sel ? irq_o : sys_reset_o) !== 1'b1 && n < lim);
    @(posedge clk_i);
  endtask

  initial begin
    {resetn_i, sleep_i, avs_read_i, avs_write_i} = 4'h0;
    avs_address_i = 6'h0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hf;
    miscompares = 0;
    comparisons = 0;
    rst;
    chk({irq_o, sys_reset_o}, 32'h0);
    foreach (rows[i]) begin
      bus(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(q, rows[i].d);
    end
    // independent watchdog: reload, then starve it in sleep
    bus(1'b1, OFF_IW_KEY, {16'h0, KEY_UNLOCK});
    bus(1'b1, OFF_IW_PSC, 32'h0);
    bus(1'b1, OFF_IW_RLD, 32'h7);
    bus(1'b1, OFF_IW_KEY, {16'h0, KEY_START});
    repeat (3) begin
      repeat (20) @(posedge clk_i);
      bus(1'b1, OFF_IW_KEY, {16'h0, KEY_RELOAD});
      bus(1'b0, OFF_IW_CNT, 32'h0);
      chk({q[15:14], q[11:1]}, 34'h1803);
      chk(sys_reset_o, 1'b0);
    end
    sleep_i <= 1'b1;
    wait_sig(1'b0, 120);
    chk(n >= 40 && n <= 72, 1'b1);
    bus(1'b0, OFF_IW_CNT, 32'h0);
    chk({q[15], q[11:0]}, 32'h1000);
    chk(sys_reset_o, 1'b1);
    sleep_i <= 1'b0;
    rst;
    bus(1'b0, OFF_IW_CNT, 32'h0);
    chk({q[15], sys_reset_o}, 32'h0);
    // window watchdog: slow timebase, early warning, then starve
    bus(1'b1, OFF_WW_CFG, 32'h1ff);
    bus(1'b1, OFF_INT_EN, 32'h1);
    bus(1'b1, OFF_WW_CTRL, 32'hff);
    wait_sig(1'b1, 2400);
    chk(n >= 1980 && n <= 2060, 1'b1);
    bus(1'b1, OFF_WW_CTRL, 32'hff);
    bus(1'b0, OFF_INT_STAT, 32'h0);
    chk({q, irq_o, sys_reset_o}, 34'h6);
    bus(1'b1, OFF_INT_CLR, 32'h1);
    bus(1'b0, OFF_INT_STAT, 32'h0);
    chk({q, irq_o}, 33'h0);
    bus(1'b1, OFF_INT_EN, 32'h0);
    bus(1'b1, OFF_WW_CTRL, 32'hc5);
    wait_sig(1'b0, 300);
    chk(n >= 150 && n <= 200, 1'b1);
    bus(1'b0, OFF_INT_STAT, 32'h0);
    chk({q, irq_o}, 33'h2);
    bus(1'b0, OFF_WW_CTRL, 32'h0);
    chk({q[7:6], sys_reset_o}, 32'h5);
    // refresh above the window while enabled
    rst;
    bus(1'b1, OFF_WW_CTRL, 32'hff);
    bus(1'b1, OFF_WW_CFG, 32'h50);
    chk(sys_reset_o, 1'b0);
    bus(1'b1, OFF_WW_CTRL, 32'hff);
    wait_sig(1'b0, 3);
    chk(sys_reset_o, 1'b1);
    close_out;
  end
endmodule
